// ### design/bil_pkg.sv
package bil_pkg;

    // Reset sequencing timing
    localparam int unsigned BIL_CLK_MHZ = 250;
    localparam int unsigned BIL_INT_RESET_US = 15;
    localparam int unsigned BIL_INT_RESET_CYC = BIL_INT_RESET_US * BIL_CLK_MHZ;

    // Image format
    localparam logic [31:0] BIL_SKIP_CRC = 32'h0D15AB1E;
    localparam logic [31:0] BIL_CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] BIL_CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] BIL_CRC_XOR = 32'hFFFFFFFF;
    localparam int unsigned BIL_SEC_BOOT_BIT = 5;
    localparam logic [1:0] BIL_BYTE_LAST = 2'h3;
    localparam int unsigned BIL_OTP_AW = 11;
    localparam logic [10:0] BIL_OTP_BASE = 11'h000;
    localparam logic [10:0] BIL_OTP_SEC_ADDR = 11'h7FF;

    // Source selection
    typedef enum logic [0:0]
    {
        BIL_SRC_FLASH = 1'b0,
        BIL_SRC_OTP = 1'b1
    } bil_src_e;

    // Loader states
    typedef enum logic [3:0]
    {
        BIL_ST_HOLD = 4'b0000,
        BIL_ST_INTRST = 4'b0001,
        BIL_ST_SECRD = 4'b0010,
        BIL_ST_SECWT = 4'b0011,
        BIL_ST_SIZE = 4'b0100,
        BIL_ST_PROG = 4'b0101,
        BIL_ST_CRC = 4'b0110,
        BIL_ST_CHECK = 4'b0111,
        BIL_ST_RUN = 4'b1000,
        BIL_ST_FAIL = 4'b1001
    } bil_state_e;

    // RAM write port
    typedef struct packed
    {
        logic en;
        logic [31:0] addr;
        logic [31:0] data;
    } bil_ram_wr_s;

endpackage

// ### design/bil_crc32.sv
`timescale 1ns/1ps
`default_nettype none
module bil_crc32
    import bil_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_clear,
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    // Result
    output logic [31:0] o_crc
);

    logic [31:0] crc_reg;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ BIL_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            crc_reg <= BIL_CRC_INIT;
        else if (i_clear)
            crc_reg <= BIL_CRC_INIT;
        else if (i_valid)
            crc_reg <= crc_step(crc_reg, i_byte);
    end

    assign o_crc = crc_reg ^ BIL_CRC_XOR;

endmodule
`default_nettype wire

// ### design/bil_loader.sv
// Summary of operation
// - While chip reset is low, hold tile reset and enable all I/O pull-downs.
// - After reset release, internal reset phase lasts 15 us before boot.
// - Security bit 5 set selects boot from one-time-programmable memory.
// - Security bit 5 clear selects boot from embedded serial flash.
// - Flash is reached through tile 0 port pins.
// - Image starts with 32-bit size word s, then s*4 program bytes.
// - Checksum word follows; marker 0x0D15AB1E skips CRC check.
// - Size and checksum words are least significant byte first.
// - Program written from lowest RAM address; execution starts there.
// - CRC covers size word and program bytes, not the checksum.
// - Reflected CRC-32, preset all ones, result inverted.
// - Secure boot bypasses boot ROM, starts at OTP address 0.
// - Security register loaded from OTP before boot source selection.
`timescale 1ns/1ps
`default_nettype none
module bil_loader
    import bil_pkg::*;
#(
    parameter int unsigned INT_RESET_CYC = BIL_INT_RESET_CYC
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Chip reset pin
    input wire logic i_chip_rst_n,
    // Tile 0 flash byte stream
    input wire logic i_flash_valid,
    input wire logic [7:0] i_flash_byte,
    output logic o_flash_ready,
    output logic o_flash_start,
    // OTP read port
    output logic o_otp_rd,
    output logic [BIL_OTP_AW-1:0] o_otp_addr,
    input wire logic i_otp_valid,
    input wire logic [31:0] i_otp_data,
    // RAM write port
    output bil_ram_wr_s o_ram_wr,
    // Status
    output logic o_tile_rst,
    output logic o_gpio_pd,
    output logic [31:0] o_sec_reg,
    output logic o_boot_src,
    output logic o_run,
    output logic [31:0] o_run_addr,
    output logic o_fail
);

    bil_state_e state_reg;
    logic [31:0] cnt_reg;
    logic [31:0] word_reg;
    logic [1:0] bidx_reg;
    logic [31:0] size_reg;
    logic [31:0] widx_reg;
    logic [31:0] sec_reg;
    logic src_otp_reg;
    logic [BIL_OTP_AW-1:0] oaddr_reg;
    logic [31:0] crc_val;
    logic crc_clear;
    logic crc_take;
    logic byte_ok;
    logic [31:0] asm_word;
    logic flash_phase;

    ////////////////////////////////////////////////////////////////////////////
    // Byte stream, only from flash in byte phases
    assign flash_phase = (state_reg == BIL_ST_SIZE) || (state_reg == BIL_ST_PROG)
        || (state_reg == BIL_ST_CRC);
    assign o_flash_ready = flash_phase && !src_otp_reg;
    assign byte_ok = o_flash_ready && i_flash_valid;
    assign asm_word = {i_flash_byte, word_reg[31:8]};
    assign crc_take = byte_ok && (state_reg != BIL_ST_CRC);
    assign crc_clear = (state_reg == BIL_ST_INTRST);

    bil_crc32 u_crc
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(crc_clear),
        .i_valid(crc_take),
        .i_byte(i_flash_byte),
        .o_crc(crc_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= BIL_ST_HOLD;
        end
        else if (!i_chip_rst_n)
        begin
            state_reg <= BIL_ST_HOLD;
        end
        else
        begin
            case (state_reg)
                BIL_ST_HOLD: state_reg <= BIL_ST_INTRST;
                BIL_ST_INTRST:
                    if (cnt_reg >= INT_RESET_CYC - 1)
                        state_reg <= BIL_ST_SECRD;
                BIL_ST_SECRD: state_reg <= BIL_ST_SECWT;
                BIL_ST_SECWT:
                    if (i_otp_valid)
                    begin
                        if (i_otp_data[BIL_SEC_BOOT_BIT])
                            state_reg <= BIL_ST_PROG;
                        else
                            state_reg <= BIL_ST_SIZE;
                    end
                BIL_ST_SIZE:
                    if (byte_ok && bidx_reg == BIL_BYTE_LAST)
                        state_reg <= (asm_word == 32'h00000000) ? BIL_ST_CRC : BIL_ST_PROG;
                BIL_ST_PROG:
                    if (src_otp_reg)
                    begin
                        state_reg <= BIL_ST_RUN;
                    end
                    else if (byte_ok && bidx_reg == BIL_BYTE_LAST && widx_reg == size_reg - 1)
                        state_reg <= BIL_ST_CRC;
                BIL_ST_CRC:
                    if (byte_ok && bidx_reg == BIL_BYTE_LAST)
                        state_reg <= BIL_ST_CHECK;
                BIL_ST_CHECK:
                    if (word_reg == BIL_SKIP_CRC || word_reg == crc_val)
                        state_reg <= BIL_ST_RUN;
                    else
                        state_reg <= BIL_ST_FAIL;
                BIL_ST_RUN: state_reg <= BIL_ST_RUN;
                BIL_ST_FAIL: state_reg <= BIL_ST_FAIL;
                default: state_reg <= BIL_ST_HOLD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset counter
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_reg <= 32'h00000000;
        else if (state_reg == BIL_ST_INTRST)
            cnt_reg <= cnt_reg + 32'h00000001;
        else
            cnt_reg <= 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly and counters
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            word_reg <= 32'h00000000;
            bidx_reg <= 2'h0;
            size_reg <= 32'h00000000;
            widx_reg <= 32'h00000000;
        end
        else if (state_reg == BIL_ST_INTRST)
        begin
            bidx_reg <= 2'h0;
            widx_reg <= 32'h00000000;
        end
        else if (byte_ok)
        begin
            word_reg <= asm_word;
            bidx_reg <= bidx_reg + 2'h1;
            if (state_reg == BIL_ST_SIZE && bidx_reg == BIL_BYTE_LAST)
                size_reg <= asm_word;
            if (state_reg == BIL_ST_PROG && bidx_reg == BIL_BYTE_LAST)
                widx_reg <= widx_reg + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RAM writes
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_ram_wr <= '0;
        else
        begin
            o_ram_wr.en <= byte_ok && state_reg == BIL_ST_PROG && bidx_reg == BIL_BYTE_LAST;
            o_ram_wr.addr <= {widx_reg[29:0], 2'h0};
            o_ram_wr.data <= asm_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Security register and source
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sec_reg <= 32'h00000000;
            src_otp_reg <= 1'b0;
        end
        else if (state_reg == BIL_ST_SECWT && i_otp_valid)
        begin
            sec_reg <= i_otp_data;
            // bit 5 picks OTP; else flash
            src_otp_reg <= i_otp_data[BIL_SEC_BOOT_BIT];
        end
    end

    // OTP read address, security word then base
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            oaddr_reg <= BIL_OTP_SEC_ADDR;
        else if (state_reg == BIL_ST_HOLD)
            oaddr_reg <= BIL_OTP_SEC_ADDR;
        else if (state_reg == BIL_ST_SECWT && i_otp_valid)
            oaddr_reg <= BIL_OTP_BASE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_otp_rd = (state_reg == BIL_ST_SECRD);
    assign o_otp_addr = oaddr_reg;
    assign o_tile_rst = (state_reg != BIL_ST_RUN);
    assign o_gpio_pd = (state_reg == BIL_ST_HOLD) || (state_reg == BIL_ST_INTRST);
    assign o_flash_start = (state_reg == BIL_ST_SECWT) && i_otp_valid
        && !i_otp_data[BIL_SEC_BOOT_BIT];
    assign o_sec_reg = sec_reg;
    assign o_boot_src = src_otp_reg;
    assign o_run = (state_reg == BIL_ST_RUN);
    // start at base; OTP address 0
    assign o_run_addr = 32'h00000000;
    assign o_fail = (state_reg == BIL_ST_FAIL);

endmodule
`default_nettype wire

// ### test/bil_loader_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bil_loader_properties
    import bil_pkg::*;
#(
    parameter int unsigned INT_RESET_CYC = BIL_INT_RESET_CYC
)
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_rst_n,
    input wire logic o_flash_ready,
    input wire logic o_flash_start,
    input wire bil_ram_wr_s o_ram_wr,
    input wire logic o_tile_rst,
    input wire logic o_gpio_pd,
    input wire logic [31:0] o_sec_reg,
    input wire logic o_boot_src,
    input wire logic o_run,
    input wire logic [31:0] o_run_addr,
    input wire logic o_fail
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    int unsigned hold_cnt_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Internal reset length
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
            hold_cnt_reg <= 0;
        else if (o_gpio_pd && i_chip_rst_n)
            hold_cnt_reg <= hold_cnt_reg + 1;
        else
            hold_cnt_reg <= 0;
    sequence s_held;
        o_gpio_pd && o_tile_rst;
    endsequence
    sequence s_word_gap;
        !o_ram_wr.en [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_HOLD_PINS: assert property (!i_chip_rst_n |=> s_held)
        else $error("pins not held in chip reset");
    AST_INT_RESET: assert property ($fell(o_gpio_pd) |-> hold_cnt_reg >= INT_RESET_CYC)
        else $error("internal reset too short");
    AST_OTP_SRC: assert property (o_run |-> o_boot_src == o_sec_reg[BIL_SEC_BOOT_BIT])
        else $error("boot source mismatch");
    AST_FLASH_SRC: assert property (o_flash_start |=> !o_sec_reg[BIL_SEC_BOOT_BIT] && !o_boot_src)
        else $error("flash start with secure bit");
    AST_READY_SRC: assert property (o_flash_ready |-> o_boot_src == BIL_SRC_FLASH)
        else $error("flash ready on otp boot");
    AST_WORD_GAP: assert property (o_ram_wr.en |=> s_word_gap)
        else $error("ram words too close");
    AST_RAM_ALIGN: assert property (o_ram_wr.en |-> o_ram_wr.addr[1:0] == 2'h0)
        else $error("ram address unaligned");
    AST_RUN_ADDR: assert property (o_run |-> o_run_addr == 32'h0 && !o_tile_rst)
        else $error("bad run state");
    AST_FAIL_HOLD: assert property ($rose(o_fail) |-> !o_run ##1 o_fail && o_tile_rst)
        else $error("fail not held");
endmodule
bind bil_loader bil_loader_properties #(.INT_RESET_CYC(INT_RESET_CYC)) u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_chip_rst_n(i_chip_rst_n), .o_flash_ready(o_flash_ready),
    .o_flash_start(o_flash_start), .o_ram_wr(o_ram_wr), .o_tile_rst(o_tile_rst),
    .o_gpio_pd(o_gpio_pd), .o_sec_reg(o_sec_reg), .o_boot_src(o_boot_src), .o_run(o_run),
    .o_run_addr(o_run_addr), .o_fail(o_fail));
`default_nettype wire

// ### test/bil_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model
(
    // Control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    // Loader side
    input wire logic i_start,
    input wire logic i_ready,
    output logic o_valid = 1'b0,
    output logic [7:0] o_byte = 8'h5A
);
    logic [7:0] mem [0:63];
    int len = 0;
    int idx;
    logic act;
    logic go;
    ////////////////////////////////////////////////////////////////////////////////
    // ordered byte stream
    always @(posedge i_clk)
    begin
        if (i_rst || i_start)
            idx = 0;
        act = !i_rst && (act || i_start);
        go = !(i_slow && o_valid && i_ready);
        if (o_valid && i_ready)
            idx = idx + 1;
        go = go && act && idx < len;
        o_valid <= go;
        o_byte <= go ? mem[idx] : ~o_byte;
    end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bil_pkg::*;
;
    typedef struct {int s; int m; logic sl; logic [31:0] sc; logic e;} bil_row_s;
    bil_row_s rows [6] = '{'{3, 0, 0, 0, 1}, '{0, 1, 1, 0, 1}, '{2, 2, 0, 0, 0},
        '{5, 3, 1, 0, 0}, '{2, 0, 1, 0, 1}, '{1, 1, 0, 32'h20, 1}};
    logic i_clk = 0, i_rst = 1, rst_n = 0, slow = 0, otp_v = 0;
    logic [31:0] otp_d = 0, sec = 0;
    logic [31:0] ew [0:7];
    wire logic f_ready, f_start, f_valid, otp_rd, run, fail, trst, pd, src;
    wire logic [7:0] f_byte;
    wire logic [10:0] otp_a;
    wire logic [31:0] sreg, raddr;
    wire bil_ram_wr_s wr;
    int failures = 0, checks_done = 0, wn = 0, first, n;
    always #2 i_clk = ~i_clk;
    bil_loader #(.INT_RESET_CYC(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_chip_rst_n(rst_n),
        .i_flash_valid(f_valid), .i_flash_byte(f_byte), .o_flash_ready(f_ready),
        .o_flash_start(f_start), .o_otp_rd(otp_rd), .o_otp_addr(otp_a), .i_otp_valid(otp_v),
        .i_otp_data(otp_d), .o_ram_wr(wr), .o_tile_rst(trst), .o_gpio_pd(pd), .o_sec_reg(sreg),
        .o_boot_src(src), .o_run(run), .o_run_addr(raddr), .o_fail(fail));
    bil_flash_model u_flash (.i_clk(i_clk), .i_rst(i_rst || !rst_n), .i_slow(slow),
        .i_start(f_start), .i_ready(f_ready), .o_valid(f_valid), .o_byte(f_byte));
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Otp answer and ram monitor
    always @(posedge i_clk)
    begin
        otp_v <= otp_rd;
        otp_d <= (otp_a == BIL_OTP_SEC_ADDR) ? sec : 32'h0;
        if (wr.en === 1'b1)
        begin
            check(wr.addr === 32'(wn * 4) && wr.data === ew[wn], "ram word");
            wn++;
        end
    end
    task automatic load(input int s, input int m);
        logic [31:0] c, w;
        int k;
        c = BIL_CRC_INIT;
        k = 0;
        for (int i = 0; i <= s + 1; i++)
        begin
            w = (i == 0) ? s : 32'h1A2B3C4D + i;
            if (i > s)
                w = (m == 1) ? BIL_SKIP_CRC : (m == 0) ? ~c : (m == 2) ? ~c ^ 32'h1 : c;
            else if (i > 0)
                ew[i - 1] = w;
            for (int b = 0; b < 4; b++)
            begin
                u_flash.mem[k] = w[8 * b +: 8];
                k++;
                if (i <= s)
                begin
                    c ^= 32'(w[8 * b +: 8]);
                    repeat (8) c = c[0] ? (c >> 1) ^ BIL_CRC_POLY : c >> 1;
                end
            end
        end
        u_flash.len = k;
    endtask
    task automatic boot;
        first = 0;
        for (n = 1; n < 600 && run !== 1'b1 && fail !== 1'b1; n++)
        begin
            @(posedge i_clk);
            #1;
            if (otp_rd === 1'b1 && first == 0)
                first = n;
        end
        if (n >= 600)
        begin
            check(1'b0, "boot timeout");
            summarize;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[r])
        begin
            @(posedge i_clk);
            rst_n <= 1'b0;
            slow <= rows[r].sl;
            sec <= rows[r].sc;
            repeat (3) @(posedge i_clk);
            load(rows[r].s, rows[r].m);
            #1;
            check(pd === 1'b1 && trst === 1'b1 && run === 1'b0, "held");
            @(posedge i_clk);
            rst_n <= 1'b1;
            wn = 0;
            boot;
            check(first == 9, "internal reset");
            check(run === rows[r].e && fail === !rows[r].e, "outcome");
            check(src === rows[r].sc[5] && sreg === rows[r].sc, "source");
            check(raddr === 32'h0 && wn == (rows[r].sc[5] ? 0 : rows[r].s), "image");
        end
        @(posedge i_clk);
        sec <= 32'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        load(4, 0);
        rst_n <= 1'b1;
        repeat (24) @(posedge i_clk);
        i_rst <= 1'b1;
        @(posedge i_clk);
        #1;
        check(trst === 1'b1 && pd === 1'b1 && run === 1'b0 && wr.en === 1'b0, "abort");
        @(posedge i_clk);
        i_rst <= 1'b0;
        wn = 0;
        boot;
        check(run === 1'b1 && wn == 4, "reboot");
        summarize;
    end
endmodule
`default_nettype wire
